// ### core/baud_clk_pkg.sv
// Purpose: Shared constants for the baud clock generation block.
// Assumes: 8-bit register port, 40 MHz reference clock.
// Notes:   Offsets are indexes in the channel's indexed control set.
package baud_clk_pkg;
  // Register indexes and address width.
  localparam int unsigned ADDR_W          = 4;
  localparam logic [3:0]  IDX_PRESCALE    = 4'h1;
  localparam logic [3:0]  IDX_SAMPLE      = 4'h2;
  localparam logic [3:0]  IDX_CLK_SRC     = 4'h3;
  localparam logic [3:0]  IDX_MODE        = 4'h4;
  localparam logic [3:0]  IDX_DIV_LOW     = 4'h5;
  localparam logic [3:0]  IDX_DIV_HIGH    = 4'h6;
  localparam logic [3:0]  IDX_STATUS      = 4'h7;
  // Field positions.
  localparam int unsigned SRC_TX_ISO_BIT  = 7;
  localparam int unsigned SRC_DTR_CLK_BIT = 4;
  localparam int unsigned SRC_RX_ISO_BIT  = 3;
  localparam int unsigned MODE_PRE_EN_BIT = 7;
  localparam int unsigned MODE_ENH_BIT    = 4;
  // Reset values.
  localparam logic [7:0]  PRESCALE_RST    = 8'h08;
  localparam logic [7:0]  SAMPLE_RST      = 8'h00;
  localparam logic [7:0]  CLK_SRC_RST     = 8'h00;
  localparam logic [7:0]  DIV_LOW_RST     = 8'h01;
  localparam logic [7:0]  DIV_HIGH_RST    = 8'h00;
  // Sample counts.
  localparam logic [4:0]  SAMPLE_DEFAULT  = 5'h10;
  localparam logic [3:0]  SAMPLE_MIN_CODE = 4'h4;
endpackage : baud_clk_pkg

// ### core/frac_prescaler.sv
// Purpose: Fractional divider, one output pulse per M+N/8 enabled input cycles.
// Assumes: M of zero is treated as one.
// Notes:   Fraction is accumulated in eighths; intervals are M or M+1 cycles.
`timescale 1ns/1ps
`default_nettype none
module frac_prescaler
  import baud_clk_pkg::*;
(
  // Clock and control.
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  // Setting.
  input  wire logic       bypass_in,
  input  wire logic [7:0] ratio_in,
  // Output pulse.
  output logic            tick_out
);
  typedef struct packed {
    logic [4:0] cnt;
    logic [2:0] acc;
    logic       extra;
    logic       tick;
  } pre_state_t;

  pre_state_t s_r;
  pre_state_t s_nxt;
  logic [4:0] m_val;
  logic [3:0] sum;

  // Next state: count M cycles, add one extra when the eighths overflow.
  always_comb
  begin
    s_nxt   = s_r;
    m_val   = (ratio_in[7:3] == 5'h00) ? 5'h01 : ratio_in[7:3];
    sum     = {1'b0, s_r.acc} + {1'b0, ratio_in[2:0]};
    s_nxt.tick = 1'b0;
    if (bypass_in)
    begin
      s_nxt.tick = 1'b1;
      s_nxt.cnt  = 5'h00;
      s_nxt.acc  = 3'h0;
      s_nxt.extra = 1'b0;
    end
    // eighths accumulate; a carry stretches the next interval by one cycle.
    else if ({1'b0, s_r.cnt} + 6'h01 >= {1'b0, m_val} + {5'h00, s_r.extra})
    begin
      s_nxt.tick  = 1'b1;
      s_nxt.cnt   = 5'h00;
      s_nxt.acc   = sum[2:0];
      s_nxt.extra = sum[3]; // Carry: the next interval is M+1 cycles.
    end
    else
      s_nxt.cnt = s_r.cnt + 5'h01;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      s_r <= '0;
    else if (ce_in)
      s_r <= s_nxt;
  end

  assign tick_out = s_r.tick;
endmodule : frac_prescaler
`default_nettype wire

// ### core/baud_clk_gen.sv
// Purpose: Baud and sample clock generation for one serial channel.
// Assumes: Register port with one-cycle read latency; external clocks are pins.
// Notes:
// Notes on behaviour
// - Prescaler divides reference clock by M plus N eighths from prescale register.
// - Prescaler disable bypasses it as divide-by-one, also the reset state.
// - Prescaler enable changes accepted only while enhanced mode bit is set.
// - Prescale register sits at index 0x01.
// - Sample clock register sits at index 0x02.
// - Sample clock register resets to 0x00, meaning 16 cycles per bit.
// - Codes 0..3 give 16 cycles; codes 4..15 give their own value.
// - Upper four bits of sample clock register read zero.
// - Writing 0x01, 0x10, 0x11 gives 16 cycles, not isochronous mode.
// - Sample clock register reads back the low four bits of the value last written.
// - Sample setting ignored by a side running isochronous.
// - Sample setting works without enhanced mode.
// - External clocks: transmitter from ring pin, receiver from data-set-ready pin.
// - Clock select bit 7 makes transmitter isochronous, bit 3 the receiver.
// - Isochronous side shifts one bit per external clock cycle.
// - Local transmit bit clock can be driven out on the terminal-ready pin.
// - Baud divider uses 16-bit divisor from low and high bytes.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module baud_clk_gen
  import baud_clk_pkg::*;
(
  // Clock, reset, enable.
  input  wire logic              REF_CLK_IN,
  input  wire logic              RST_IN,
  input  wire logic              CE_IN,
  // Register port.
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [7:0]        WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [7:0]        RDATA_OUT,
  // External bit clocks, active-low pins.
  input  wire logic              RING_N_IN,
  input  wire logic              DSR_N_IN,
  // Bit clock strobes to the shifters.
  output logic                   TX_SAMPLE_OUT,
  output logic                   TX_BIT_OUT,
  output logic                   RX_SAMPLE_OUT,
  output logic                   RX_BIT_OUT,
  // Terminal-ready pin level.
  output logic                   DTR_N_OUT
);
  typedef struct packed {
    logic [7:0]  prescale;
    logic [7:0]  sample;
    logic [7:0]  clk_src;
    logic        enh;
    logic        pre_en;
    logic [7:0]  div_lo;
    logic [7:0]  div_hi;
    logic [15:0] div_cnt;
    logic [4:0]  tx_cnt;
    logic [4:0]  rx_cnt;
    logic [1:0]  ri_sync;
    logic [1:0]  dsr_sync;
    logic        ri_prev;
    logic        dsr_prev;
    logic        tx_samp;
    logic        tx_bit;
    logic        rx_samp;
    logic        rx_bit;
    logic        bit_clk;
    logic        dtr_n;
    logic [7:0]  rdata;
  } gen_state_t;

  gen_state_t s_r;
  gen_state_t s_nxt;
  logic       pre_tick;
  logic [4:0] per_bit;
  logic [15:0] div_val;
  logic       nx_tick;
  logic       tx_iso;
  logic       rx_iso;
  logic       ri_rise;
  logic       dsr_rise;

  // Fractional prescaler stage.
  frac_prescaler u_pre (
    .clk_in    (REF_CLK_IN),
    .rst_in    (RST_IN),
    .ce_in     (CE_IN),
    .bypass_in (~s_r.pre_en),
    .ratio_in  (s_r.prescale),
    .tick_out  (pre_tick)
  );

  // Next-state logic for registers, dividers and strobes.
  always_comb
  begin
    s_nxt = s_r;
    // map code to cycles per bit.
    // small codes fall back to 16.
    per_bit = (s_r.sample[3:0] < SAMPLE_MIN_CODE) ? SAMPLE_DEFAULT : {1'b0, s_r.sample[3:0]};
    // zero divisor is treated as one.
    div_val = {s_r.div_hi, s_r.div_lo};
    if (div_val == 16'h0000)
      div_val = 16'h0001;
    nx_tick = 1'b0;
    tx_iso  = s_r.clk_src[SRC_TX_ISO_BIT];
    rx_iso  = s_r.clk_src[SRC_RX_ISO_BIT];
    // edges of the synchronised external clocks.
    ri_rise  = s_r.ri_sync[1] & ~s_r.ri_prev;
    dsr_rise = s_r.dsr_sync[1] & ~s_r.dsr_prev;
    s_nxt.ri_sync  = {s_r.ri_sync[0], ~RING_N_IN};
    s_nxt.dsr_sync = {s_r.dsr_sync[0], ~DSR_N_IN};
    s_nxt.ri_prev  = s_r.ri_sync[1];
    s_nxt.dsr_prev = s_r.dsr_sync[1];
    s_nxt.tx_samp = 1'b0;
    s_nxt.tx_bit  = 1'b0;
    s_nxt.rx_samp = 1'b0;
    s_nxt.rx_bit  = 1'b0;

    if (pre_tick)
    begin
      if (s_r.div_cnt + 16'h0001 >= div_val)
      begin
        s_nxt.div_cnt = 16'h0000;
        nx_tick       = 1'b1;
      end
      else
        s_nxt.div_cnt = s_r.div_cnt + 16'h0001;
    end

    // sample count only for a non-isochronous side.
    // isochronous side pulses once per external clock cycle.
    if (tx_iso)
    begin
      s_nxt.tx_samp = ri_rise;
      s_nxt.tx_bit  = ri_rise;
      s_nxt.tx_cnt  = 5'h00;
    end
    else if (nx_tick)
    begin
      s_nxt.tx_samp = 1'b1;
      if (s_r.tx_cnt + 5'h01 >= per_bit)
      begin
        s_nxt.tx_cnt = 5'h00;
        s_nxt.tx_bit = 1'b1;
      end
      else
        s_nxt.tx_cnt = s_r.tx_cnt + 5'h01;
    end
    if (rx_iso)
    begin
      s_nxt.rx_samp = dsr_rise;
      s_nxt.rx_bit  = dsr_rise;
      s_nxt.rx_cnt  = 5'h00;
    end
    else if (nx_tick)
    begin
      s_nxt.rx_samp = 1'b1;
      if (s_r.rx_cnt + 5'h01 >= per_bit)
      begin
        s_nxt.rx_cnt = 5'h00;
        s_nxt.rx_bit = 1'b1;
      end
      else
        s_nxt.rx_cnt = s_r.rx_cnt + 5'h01;
    end

    // Local bit clock toggles at each transmit bit strobe.
    if (s_nxt.tx_bit)
      s_nxt.bit_clk = ~s_r.bit_clk;
    // bit clock on the terminal-ready pin when selected.
    s_nxt.dtr_n = s_r.clk_src[SRC_DTR_CLK_BIT] ? s_r.bit_clk : 1'b1;

    // Register writes.
    if (WR_IN)
    begin
      case (ADDR_IN)
        IDX_PRESCALE: s_nxt.prescale = WDATA_IN;
        IDX_SAMPLE:   s_nxt.sample = WDATA_IN;
        IDX_CLK_SRC:  s_nxt.clk_src = WDATA_IN;
        IDX_MODE:
        begin
          s_nxt.enh = WDATA_IN[MODE_ENH_BIT];
          // enable changes only in enhanced mode.
          if (s_r.enh)
            s_nxt.pre_en = WDATA_IN[MODE_PRE_EN_BIT];
        end
        IDX_DIV_LOW:  s_nxt.div_lo = WDATA_IN;
        IDX_DIV_HIGH: s_nxt.div_hi = WDATA_IN;
        default:      s_nxt.div_cnt = s_nxt.div_cnt;
      endcase
    end

    // Register reads, data valid the following cycle.
    s_nxt.rdata = 8'h00;
    if (RD_IN)
    begin
      case (ADDR_IN)
        IDX_PRESCALE: s_nxt.rdata = s_r.prescale;
        IDX_SAMPLE:   s_nxt.rdata = {4'h0, s_r.sample[3:0]};
        IDX_CLK_SRC:  s_nxt.rdata = s_r.clk_src;
        IDX_MODE:     s_nxt.rdata = {s_r.pre_en, 2'h0, s_r.enh, 4'h0};
        IDX_DIV_LOW:  s_nxt.rdata = s_r.div_lo;
        IDX_DIV_HIGH: s_nxt.rdata = s_r.div_hi;
        IDX_STATUS:   s_nxt.rdata = {3'h0, s_r.tx_cnt};
        default:      s_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register; clock enable freezes everything.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      s_r          <= '0;
      s_r.sample   <= SAMPLE_RST;
      s_r.pre_en   <= 1'b0;
      s_r.prescale <= PRESCALE_RST;
      s_r.clk_src  <= CLK_SRC_RST;
      s_r.div_lo   <= DIV_LOW_RST;
      s_r.div_hi   <= DIV_HIGH_RST;
      s_r.dtr_n    <= 1'b1;
    end
    else if (CE_IN)
      s_r <= s_nxt;
  end

  assign RDATA_OUT     = s_r.rdata;
  assign TX_SAMPLE_OUT = s_r.tx_samp;
  assign TX_BIT_OUT    = s_r.tx_bit;
  assign RX_SAMPLE_OUT = s_r.rx_samp;
  assign RX_BIT_OUT    = s_r.rx_bit;
  assign DTR_N_OUT     = s_r.dtr_n;

  a_pre_en_gate: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (CE_IN && WR_IN && ADDR_IN == IDX_MODE && !s_r.enh) |=> $stable(s_r.pre_en))
    else $error("Prescaler enable changed outside enhanced mode.");

  // bypass gives a tick every cycle.
  a_bypass_tick: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (CE_IN && !s_r.pre_en) ##1 CE_IN |-> pre_tick)
    else $error("Bypassed prescaler did not tick every cycle.");

  // upper nibble of sample read is zero.
  a_sample_upper: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (CE_IN && RD_IN && ADDR_IN == IDX_SAMPLE) |=> RDATA_OUT[7:4] == 4'h0)
    else $error("Sample register upper bits not zero.");

  // read returns last written low nibble.
  a_sample_back: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (CE_IN && WR_IN && ADDR_IN == IDX_SAMPLE) ##1 (CE_IN && RD_IN && ADDR_IN == IDX_SAMPLE)
    |=> RDATA_OUT[3:0] == $past(WDATA_IN[3:0], 2))
    else $error("Sample register read-back mismatch.");

  a_sample_map: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (s_r.sample[3:0] < 4'h4) |-> per_bit == 5'h10)
    else $error("Low sample code did not select sixteen.");

  a_sample_rst: assert property (@(posedge REF_CLK_IN)
    $past(RST_IN) |-> s_r.sample == 8'h00)
    else $error("Sample register not cleared by reset.");

  a_tx_iso_bit: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (CE_IN && tx_iso && ri_rise) |=> TX_BIT_OUT)
    else $error("Isochronous transmit bit strobe missing.");

  // terminal-ready idle high when clock output off.
  a_dtr_idle: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (CE_IN && !s_r.clk_src[SRC_DTR_CLK_BIT]) |=> DTR_N_OUT)
    else $error("Terminal-ready pin not idle.");

  a_rx_iso_bit: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (CE_IN && rx_iso && dsr_rise) |=> RX_BIT_OUT)
    else $error("Isochronous receive bit strobe missing.");

  // transmit sample count idles in isochronous mode.
  a_tx_iso_idle: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (CE_IN && tx_iso) |=> s_r.tx_cnt == 5'h00)
    else $error("Transmit sample count ran in isochronous mode.");

  // receive sample count idles in isochronous mode.
  a_rx_iso_idle: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (CE_IN && rx_iso) |=> s_r.rx_cnt == 5'h00)
    else $error("Receive sample count ran in isochronous mode.");

  // a divisor of one passes every prescaled tick.
  a_div_one: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (CE_IN && pre_tick && !tx_iso && div_val == 16'h0001) |=> TX_SAMPLE_OUT)
    else $error("Divisor of one dropped a sample strobe.");

  // enable write taken while enhanced mode is set.
  a_pre_en_take: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (CE_IN && WR_IN && ADDR_IN == IDX_MODE && s_r.enh)
    |=> s_r.pre_en == $past(WDATA_IN[MODE_PRE_EN_BIT]))
    else $error("Prescaler enable write lost in enhanced mode.");
endmodule : baud_clk_gen
`default_nettype wire

// ### verif/ext_bit_clock.sv
// Purpose: External 1x bit clock source for the isochronous clock pins.
// Assumes: Both clocks park high while run_in is low.
// Notes:   The receive clock is slower so that the two pins can be told apart.
`timescale 1ns/1ps
`default_nettype none
module ext_bit_clock #(
  parameter int HALF_TX = 5,
  parameter int HALF_RX = 7
) (
  // Clock and control.
  input  wire logic clk_in,
  input  wire logic run_in,
  // Clock pins.
  output logic      ring_n_out,
  output logic      dsr_n_out
);
  int cnt_tx;
  int cnt_rx;
  // drives both clocks
  // Each pin toggles every half period while running and parks high otherwise.
  always_ff @(posedge clk_in)
  begin
    if (!run_in)
    begin
      cnt_tx     <= 0;
      cnt_rx     <= 0;
      ring_n_out <= 1'b1;
      dsr_n_out  <= 1'b1;
    end
    else
    begin
      cnt_tx <= (cnt_tx == HALF_TX - 1) ? 0 : cnt_tx + 1;
      cnt_rx <= (cnt_rx == HALF_RX - 1) ? 0 : cnt_rx + 1;
      if (cnt_tx == HALF_TX - 1)
        ring_n_out <= ~ring_n_out;
      if (cnt_rx == HALF_RX - 1)
        dsr_n_out <= ~dsr_n_out;
    end
  end
endmodule // ext_bit_clock
`default_nettype wire

// ### verif/baud_clk_gen_tb_top.sv
// Purpose: Self-checking bench for the baud clock generator.
// Assumes: Register port with one-cycle read latency.
// Notes:   Bit periods are counted between consecutive bit strobes.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("FAIL %s exp %0h got %0h", nm, exp, got); end end
module baud_clk_gen_tb_top;
  import baud_clk_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0]        wdata = 8'h00;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              ce = 1'b1;
  logic              run = 1'b0;
  logic [7:0]        rdata;
  logic              ring_n, dsr_n, tx_smp, tx_bit, rx_smp, rx_bit, dtr_n;
  int                fail_count = 0;
  int                cmp_count = 0;
  int                cycles = 0;
  int                p;
  int                n;
  logic [7:0]        v;
  logic [7:0]        codes [18];

  // Clock generation.
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  baud_clk_gen baud_clk_gen_i (.REF_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .RING_N_IN(ring_n), .DSR_N_IN(dsr_n), .TX_SAMPLE_OUT(tx_smp), .TX_BIT_OUT(tx_bit),
    .RX_SAMPLE_OUT(rx_smp), .RX_BIT_OUT(rx_bit), .DTR_N_OUT(dtr_n));

  ext_bit_clock ext_bit_clock_i (.clk_in(clk), .run_in(run), .ring_n_out(ring_n),
    .dsr_n_out(dsr_n));

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One-cycle register write.
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle register read; data is taken at the edge that closes the data cycle.
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  // Cycles between second and third strobe: 0 tx bit, 1 rx bit, 2 tx sample, 3 rx sample.
  task automatic period(input int sel, output int q);
    int   m;
    logic s;
    for (int k = 0; k < 3; k++)
    begin
      m = 0;
      do
      begin
        @(posedge clk);
        m++;
        s = (sel == 0) ? tx_bit : (sel == 1) ? rx_bit : (sel == 2) ? tx_smp : rx_smp;
      end while ((s !== 1'b1) && m < 2000);
      q = m;
    end
  endtask

  // Cuts a hang short.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_reg(IDX_SAMPLE, v);   `CHK("sample rst", 8'h00, v)
    rd_reg(4'h0, v);         `CHK("unmapped", 8'h00, v)
    period(0, p);            `CHK("default bit", 16, p)
    for (int i = 0; i < 16; i++)
      codes[i] = 8'(i);
    codes[16] = 8'h10;
    codes[17] = 8'h11;
    // Every sample code, including the codes that must not select 1x mode.
    foreach (codes[i])
    begin
      wr_reg(IDX_SAMPLE, codes[i]);
      rd_reg(IDX_SAMPLE, v); `CHK("sample rd", {4'h0, codes[i][3:0]}, v)
      period(0, p);
      `CHK("sample bit", (codes[i][3:0] < 4) ? 16 : int'(codes[i][3:0]), p)
    end
    wr_reg(IDX_SAMPLE, 8'h00);
    wr_reg(IDX_PRESCALE, 8'h10);
    rd_reg(IDX_PRESCALE, v); `CHK("prescale rd", 8'h10, v)
    // A write while the clock enable is low must not land.
    ce <= 1'b0;
    wr_reg(IDX_PRESCALE, 8'h55);
    ce <= 1'b1;
    rd_reg(IDX_PRESCALE, v); `CHK("frozen write", 8'h10, v)
    wr_reg(IDX_MODE, 8'h80);
    period(0, p);            `CHK("enable refused", 16, p)
    wr_reg(IDX_MODE, 8'h10);
    wr_reg(IDX_MODE, 8'h90);
    period(0, p);            `CHK("prescale 2", 32, p)
    wr_reg(IDX_PRESCALE, 8'h0C);
    wr_reg(IDX_SAMPLE, 8'h04);
    period(0, p);            `CHK("prescale 1.5", 6, p)
    wr_reg(IDX_MODE, 8'h10);
    period(0, p);            `CHK("bypass", 4, p)
    wr_reg(IDX_DIV_LOW, 8'h03);
    period(0, p);            `CHK("div 3", 12, p)
    period(2, p);            `CHK("tx sample", 3, p)
    period(3, p);            `CHK("rx sample", 3, p)
    wr_reg(IDX_DIV_HIGH, 8'h01);
    period(1, p);            `CHK("div 259", 1036, p)
    wr_reg(IDX_DIV_HIGH, 8'h00);
    wr_reg(IDX_DIV_LOW, 8'h01);
    `CHK("dtr idle", 1'b1, dtr_n)
    // The clock pins toggle from here on, so nothing watches them as modem status.
    run <= 1'b1;
    wr_reg(IDX_CLK_SRC, 8'h88);
    period(0, p);            `CHK("iso tx", 10, p)
    period(1, p);            `CHK("iso rx", 14, p)
    period(3, p);            `CHK("iso rx smp", 14, p)
    wr_reg(IDX_CLK_SRC, 8'h98);
    // Let the pin settle onto the bit clock before counting edges.
    repeat (2) @(posedge clk);
    n = 0;
    v[0] = dtr_n;
    repeat (60)
    begin
      @(posedge clk);
      if (dtr_n !== v[0])
        n++;
      v[0] = dtr_n;
    end
    `CHK("dtr clock", 6, n)
    wrap_up();
  end
endmodule // baud_clk_gen_tb_top
`default_nettype wire
